//--- logic/lbfc_rx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lbfc_rx_checker (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SYSREF,
  input wire logic FEC_FMT,
  output logic [63:0] PAY_DATA,
  output logic PAY_VALID,
  output logic MB_LOCK,
  output logic MB_END,
  output logic EMB_END,
  output logic HDR_ERR,
  output logic CRC_ERR,
  output logic NEED_SYSREF,
  lbfc_link_if.rx link
);

  typedef enum logic [2:0] {
    LBFC_SEARCH = 3'h1,
    LBFC_LOCK = 3'h2,
    LBFC_WAIT = 3'h4
  } lbfc_rx_state_t;

  function automatic logic [11:0] crc_from(input logic [31:0] w);
    logic [11:0] c;
    c = 12'h000;
    for (int g = 0; g < lbfc_pkg::CRC_W; g++) begin
      c[lbfc_pkg::CRC_W-1-g] = w[lbfc_pkg::crc_slot(g)];
    end
    return c;
  endfunction

  function automatic logic [63:0] take_payload(input logic [65:0] b);
    logic [63:0] d;
    d = 64'h0;
    for (int k = 0; k < lbfc_pkg::OCTETS; k++) begin
      for (int j = 0; j < lbfc_pkg::OCT_W; j++) begin
        d[k*lbfc_pkg::OCT_W + j] = b[lbfc_pkg::PAY_POS + k*lbfc_pkg::OCT_W + (lbfc_pkg::OCT_W-1-j)];
      end
    end
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [2:0] sync_r;
  logic lvl_r;
  logic lvl_nxt;
  logic sysref_rise;
  lbfc_rx_state_t st_r;
  lbfc_rx_state_t st_nxt;
  logic [lbfc_pkg::IDX_W-1:0] idx_r;
  logic [lbfc_pkg::IDX_W-1:0] idx_nxt;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [11:0] crc_r;
  logic [11:0] crc_nxt;
  logic [11:0] prev_r;
  logic [11:0] prev_nxt;
  logic have_prev_r;
  logic have_prev_nxt;
  logic [lbfc_pkg::ERR_W-1:0] herr_r;
  logic [lbfc_pkg::ERR_W-1:0] herr_nxt;
  logic [lbfc_pkg::ERR_W-1:0] miss_r;
  logic [lbfc_pkg::ERR_W-1:0] miss_nxt;
  logic [lbfc_pkg::ERR_W-1:0] conf_r;
  logic [lbfc_pkg::ERR_W-1:0] conf_nxt;
  logic [63:0] data_nxt;
  logic [63:0] data_r;
  logic pv_nxt;
  logic pv_r;
  logic mbe_nxt;
  logic mbe_r;
  logic embe_nxt;
  logic embe_r;
  logic herr_p_nxt;
  logic herr_p_r;
  logic crce_nxt;
  logic crce_r;
  logic hdr_ok;
  logic pilot_hit;
  logic last_blk;

  always_comb begin
    lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    sysref_rise = lvl_nxt & ~lvl_r;
    st_nxt = st_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    crc_nxt = crc_r;
    prev_nxt = prev_r;
    have_prev_nxt = have_prev_r;
    herr_nxt = herr_r;
    miss_nxt = miss_r;
    conf_nxt = conf_r;
    mbe_nxt = 1'b0;
    embe_nxt = 1'b0;
    herr_p_nxt = 1'b0;
    crce_nxt = 1'b0;
    data_nxt = take_payload(link.blk);
    pv_nxt = 1'b0;
    // header checked at the fixed block boundary
    hdr_ok = (link.blk[1:0] == lbfc_pkg::HDR_ONE) || (link.blk[1:0] == lbfc_pkg::HDR_ZERO);
    sh_nxt = {link.blk[1:0] == lbfc_pkg::HDR_ONE, sh_r[31:1]};
    pilot_hit = FEC_FMT ? ((sh_nxt & lbfc_pkg::FEC_PILOT_MASK) == lbfc_pkg::FEC_PILOT_VALUE)
                        : ((sh_nxt & lbfc_pkg::CRC_PILOT_MASK) == lbfc_pkg::CRC_FIXED_ONES);
    last_blk = (idx_r == lbfc_pkg::IDX_LAST);
    if (link.blk_valid) begin
      idx_nxt = idx_r + 5'h01;
      crc_nxt = lbfc_pkg::crc_block((idx_r == lbfc_pkg::IDX_FIRST) ? lbfc_pkg::CRC_INIT : crc_r, link.blk);
      case (st_r)
        LBFC_SEARCH: begin
          if (pilot_hit) begin
            idx_nxt = lbfc_pkg::IDX_FIRST;
            // fec pilot confirmed at same position
            conf_nxt = (last_blk && conf_r != 3'h0) ? conf_r + 3'h1 : 3'h1;
            if (!FEC_FMT || conf_nxt >= lbfc_pkg::MB_CONFIRM) begin
              st_nxt = LBFC_LOCK;
              have_prev_nxt = 1'b0;
              herr_nxt = 3'h0;
              miss_nxt = 3'h0;
            end
          end
        end
        LBFC_LOCK: begin
          pv_nxt = 1'b1;
          if (!hdr_ok) begin
            herr_p_nxt = 1'b1;
            herr_nxt = herr_r + 3'h1;
          end
          if (last_blk) begin
            herr_nxt = hdr_ok ? 3'h0 : 3'h1;
            if (pilot_hit) begin
              mbe_nxt = 1'b1;
              embe_nxt = sh_nxt[lbfc_pkg::EXT_MULTIBLOCK_END_FLAG_BIT];
              miss_nxt = 3'h0;
              // own crc against next multiblock word
              crce_nxt = have_prev_r & ~FEC_FMT & (crc_from(sh_nxt) != prev_r);
              prev_nxt = crc_nxt;
              have_prev_nxt = 1'b1;
            end else begin
              miss_nxt = miss_r + 3'h1;
            end
          end
          if (herr_nxt >= lbfc_pkg::HDR_ERR_LIMIT || miss_nxt >= lbfc_pkg::PILOT_MISS_LIMIT) begin
            st_nxt = LBFC_WAIT;
          end
        end
        LBFC_WAIT: begin
          if (sysref_rise) begin
            st_nxt = LBFC_SEARCH;
            conf_nxt = 3'h0;
          end
        end
        default: begin
          st_nxt = LBFC_SEARCH;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_r <= lbfc_pkg::SYNC_RST;
      lvl_r <= 1'b0;
      st_r <= LBFC_SEARCH;
      idx_r <= lbfc_pkg::IDX_FIRST;
      sh_r <= 32'h0000_0000;
      crc_r <= lbfc_pkg::CRC_INIT;
      prev_r <= lbfc_pkg::CRC_INIT;
      have_prev_r <= 1'b0;
      herr_r <= 3'h0;
      miss_r <= 3'h0;
      conf_r <= 3'h0;
      data_r <= 64'h0;
      pv_r <= 1'b0;
      mbe_r <= 1'b0;
      embe_r <= 1'b0;
      herr_p_r <= 1'b0;
      crce_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], SYSREF};
      lvl_r <= lvl_nxt;
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      sh_r <= link.blk_valid ? sh_nxt : sh_r;
      crc_r <= crc_nxt;
      prev_r <= prev_nxt;
      have_prev_r <= have_prev_nxt;
      herr_r <= herr_nxt;
      miss_r <= miss_nxt;
      conf_r <= conf_nxt;
      data_r <= data_nxt;
      pv_r <= pv_nxt;
      mbe_r <= mbe_nxt;
      embe_r <= embe_nxt;
      herr_p_r <= herr_p_nxt;
      crce_r <= crce_nxt;
    end
  end

  // status outputs leave from flops loaded from st_nxt, so they match the state with no lag
  logic lock_r;
  logic wait_r;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      lock_r <= (st_nxt == LBFC_LOCK);
      wait_r <= (st_nxt == LBFC_WAIT);
    end
  end

  assign PAY_DATA = data_r;
  assign PAY_VALID = pv_r;
  assign MB_LOCK = lock_r;
  assign MB_END = mbe_r;
  assign EMB_END = embe_r;
  assign HDR_ERR = herr_p_r;
  assign CRC_ERR = crce_r;
  assign NEED_SYSREF = wait_r;

endmodule // lbfc_rx_checker
`default_nettype wire

//--- logic/lbfc_tx_framer.sv
`timescale 1ns/1ps
`default_nettype none
module lbfc_tx_framer (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SYSREF,
  input wire logic [63:0] PAY_DATA,
  input wire logic PAY_VALID,
  output logic EXT_MULTIBLOCK_TIMING_CLOCK_EDGE,
  output logic SYSREF_PHASE_ERR,
  output logic EXT_MULTIBLOCK_TIMING_CLOCK_ALIGNED,
  output logic [31:0] STREAM_WORD,
  output logic [15:0] MB_COUNT,
  lbfc_link_if.tx link
);

  //////////////////////////////////////////////////////////////////////////////
  // with one multiblock per extended multiblock, every multiblock ends one
  // single multiblock per extended
  localparam logic EXT_MULTIBLOCK_END_FLAG_VAL = (lbfc_pkg::EMB_MBS == 1);

  function automatic logic [31:0] build_stream(input logic [11:0] crc);
    logic [31:0] w;
    w = lbfc_pkg::CRC_FIXED_ONES;
    w[lbfc_pkg::EXT_MULTIBLOCK_END_FLAG_BIT] = EXT_MULTIBLOCK_END_FLAG_VAL;
    for (int g = 0; g < lbfc_pkg::CRC_W; g++) begin
      w[lbfc_pkg::crc_slot(g)] = crc[lbfc_pkg::CRC_W-1-g];
    end
    return w;
  endfunction

  // octet k bit j goes to position 2+8k+(7-j): octet msb first on the line
  // octet placement after header
  function automatic logic [63:0] place_payload(input logic [63:0] data);
    logic [63:0] p;
    p = 64'h0;
    for (int k = 0; k < lbfc_pkg::OCTETS; k++) begin
      for (int j = 0; j < lbfc_pkg::OCT_W; j++) begin
        p[k*lbfc_pkg::OCT_W + (lbfc_pkg::OCT_W-1-j)] = data[k*lbfc_pkg::OCT_W + j];
      end
    end
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sysref: three-stage sampling, a level counts once stages two and three agree
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic sysref_rise;

  always_comb begin
    sync_nxt = {sync_r[1:0], SYSREF};
    lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    sysref_rise = lvl_nxt & ~lvl_r;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_r <= lbfc_pkg::SYNC_RST;
      lvl_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // framing state: block index, crc, stream word, outgoing block
  logic [lbfc_pkg::IDX_W-1:0] idx_r;
  logic [lbfc_pkg::IDX_W-1:0] idx_nxt;
  logic [11:0] crc_r;
  logic [11:0] crc_nxt;
  logic [31:0] stream_r;
  logic [31:0] stream_nxt;
  logic [65:0] blk_r;
  logic [65:0] blk_nxt;
  logic blk_valid_r;
  logic ext_multiblock_timing_clock_r;
  logic ext_multiblock_timing_clock_nxt;
  logic phase_err_r;
  logic phase_err_nxt;
  logic aligned_r;
  logic aligned_nxt;
  logic [15:0] mb_cnt_r;
  logic [15:0] mb_cnt_nxt;
  logic [63:0] pay_scr;
  logic first_blk;
  logic sbit;

  // timing: block index, multiblock edge, sysref phase
  always_comb begin
    first_blk = (idx_r == lbfc_pkg::IDX_FIRST);
    idx_nxt = sysref_rise ? lbfc_pkg::IDX_FIRST : idx_r + 5'h01;
    // the pulse lines up with block zero on the link, one edge after its build
    ext_multiblock_timing_clock_nxt = first_blk;
    // a continuous sysref must land where the index would wrap anyway
    // periodic sysref phase check
    phase_err_nxt = sysref_rise & aligned_r & (idx_r != lbfc_pkg::IDX_LAST);
    aligned_nxt = aligned_r | sysref_rise;
    mb_cnt_nxt = first_blk ? mb_cnt_r + 16'h0001 : mb_cnt_r;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_r <= lbfc_pkg::IDX_FIRST;
      ext_multiblock_timing_clock_r <= 1'b0;
      phase_err_r <= 1'b0;
      aligned_r <= 1'b0;
      mb_cnt_r <= 16'h0000;
    end else begin
      idx_r <= idx_nxt;
      ext_multiblock_timing_clock_r <= ext_multiblock_timing_clock_nxt;
      phase_err_r <= phase_err_nxt;
      aligned_r <= aligned_nxt;
      mb_cnt_r <= mb_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crc and stream word; a sysref cut still sends the parity of the cut
  // multiblock, so the far end sees no bad compare after a realignment
  always_comb begin
    // payload arrives already scrambled; an idle cycle sends zero octets
    pay_scr = PAY_VALID ? PAY_DATA : 64'h0;
    // previous parity read at block zero
    stream_nxt = first_blk ? build_stream(crc_r) : stream_r;
    // stream bit index follows block index
    sbit = stream_nxt[idx_r];
    // cleared at block zero, header excluded
    crc_nxt = lbfc_pkg::crc_block(first_blk ? lbfc_pkg::CRC_INIT : crc_r, blk_nxt);
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      crc_r <= lbfc_pkg::CRC_INIT;
      stream_r <= 32'h0000_0000;
    end else begin
      crc_r <= crc_nxt;
      stream_r <= stream_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outgoing block: header from the stream bit, octets msb first
  always_comb begin
    blk_nxt[65:2] = place_payload(pay_scr);
    blk_nxt[1:0] = sbit ? lbfc_pkg::HDR_ONE : lbfc_pkg::HDR_ZERO;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      blk_r <= 66'h0;
      blk_valid_r <= 1'b0;
    end else begin
      blk_r <= blk_nxt;
      // no back-pressure: a block leaves on every edge after reset
      blk_valid_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crc-12 stream format only here
  assign link.blk = blk_r;
  assign link.blk_valid = blk_valid_r;
  assign EXT_MULTIBLOCK_TIMING_CLOCK_EDGE = ext_multiblock_timing_clock_r;
  assign SYSREF_PHASE_ERR = phase_err_r;
  assign EXT_MULTIBLOCK_TIMING_CLOCK_ALIGNED = aligned_r;
  assign STREAM_WORD = stream_r;
  assign MB_COUNT = mb_cnt_r;

endmodule // lbfc_tx_framer
`default_nettype wire

//--- shared/lbfc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lbfc_link_if;
  logic [65:0] blk;
  logic blk_valid;
  modport tx (output blk, output blk_valid);
  modport rx (input blk, input blk_valid);
endinterface
`default_nettype wire

//--- shared/lbfc_pkg.sv
`default_nettype none
package lbfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // block layout: vector index equals transmitted bit position
  localparam int BLK_W = 66;
  localparam int PAY_W = 64;
  localparam int OCTETS = 8;
  localparam int OCT_W = 8;
  localparam int PAY_POS = 2;
  // header bit 0 sits in blk[0]: pattern 01 means blk[0]=0, blk[1]=1
  localparam logic [1:0] HDR_ONE = 2'h2;
  localparam logic [1:0] HDR_ZERO = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // multiblock framing
  localparam int MB_BLOCKS = 32;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] IDX_FIRST = 5'h00;
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;
  localparam int EMB_MBS = 1;
  localparam int EXT_MULTIBLOCK_TIMING_CLOCK_BITS = BLK_W * MB_BLOCKS * EMB_MBS;
  localparam int STREAM_W = 32;
  localparam int EXT_MULTIBLOCK_END_FLAG_BIT = 22;
  localparam logic [31:0] CRC_FIXED_ONES = 32'h80a8_8888;
  localparam logic [31:0] CRC_PILOT_MASK = 32'hf8a8_8888;
  localparam logic [31:0] FEC_PILOT_MASK = 32'hf800_0000;
  localparam logic [31:0] FEC_PILOT_VALUE = 32'h8000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // crc-12, polynomial given in implicit-one form, top term explicit
  localparam int CRC_W = 12;
  localparam logic [11:0] CRC_POLY_IMPL = 12'h987;
  localparam logic [11:0] CRC_TAPS = {CRC_POLY_IMPL[10:0], 1'b1};
  localparam logic [11:0] CRC_INIT = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // receiver supervision
  localparam int ERR_W = 3;
  localparam logic [ERR_W-1:0] HDR_ERR_LIMIT = 3'h4;
  localparam logic [ERR_W-1:0] PILOT_MISS_LIMIT = 3'h2;
  localparam logic [ERR_W-1:0] MB_CONFIRM = 3'h3;
  localparam logic [2:0] SYNC_RST = 3'h0;

  // serial crc over payload positions 2..65, earliest position first
  function automatic logic [11:0] crc_block(input logic [11:0] crc_in, input logic [65:0] blk);
    logic [11:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int p = PAY_POS; p < BLK_W; p++) begin
      fb = blk[p] ^ c[CRC_W-1];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_TAPS : 12'h000);
    end
    return c;
  endfunction

  // stream position holding crc bit (11 - g): skips every fourth bit
  function automatic int crc_slot(input int g);
    return g + g / 3;
  endfunction

endpackage
`default_nettype wire

//--- sim/lbfc_props.sv
`timescale 1ns/1ps
`default_nettype none
module lbfc_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [65:0] blk,
  input wire logic blk_valid,
  input wire logic EXT_MULTIBLOCK_TIMING_CLOCK_EDGE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  logic [31:0] str_r;
  logic [5:0] cnt_r;
  logic [1:0] ecnt_r;
  logic [11:0] crc_r;
  logic [11:0] crc_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // independent serial crc, so a shared slip cannot hide itself
  function automatic logic [11:0] pcrc(input logic [11:0] c, input logic [65:0] b);
    for (int p = 2; p < 66; p++) begin
      c = {c[10:0], 1'b0} ^ ((b[p] ^ c[11]) ? 12'h30f : 12'h000);
    end
    return c;
  endfunction

  function automatic logic [11:0] field(input logic [31:0] s);
    for (int g = 0; g < 12; g++) begin
      field[11 - g] = s[g + g / 3];
    end
  endfunction

  // edge count gates checks: the first multiblock may be cut short by sysref
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      str_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      ecnt_r <= 2'h0;
      crc_r <= 12'h000;
      crc_prev_r <= 12'h000;
    end else if (blk_valid) begin
      str_r <= {blk[1], str_r[31:1]};
      cnt_r <= EXT_MULTIBLOCK_TIMING_CLOCK_EDGE ? 6'h00 : cnt_r + 6'h01;
      crc_r <= pcrc(EXT_MULTIBLOCK_TIMING_CLOCK_EDGE ? 12'h000 : crc_r, blk);
      if (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE) begin
        crc_prev_r <= crc_r;
        ecnt_r <= (ecnt_r == 2'h3) ? ecnt_r : ecnt_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  hdr_differ_a: assert property (blk_valid |-> blk[0] != blk[1])
    else $error("header bits equal");
  valid_hold_a: assert property (blk_valid |=> blk_valid)
    else $error("block valid dropped");
  first_block_a: assert property ($rose(blk_valid) |-> EXT_MULTIBLOCK_TIMING_CLOCK_EDGE)
    else $error("first block not index zero");
  mb_period_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r >= 2'h2 |-> cnt_r == 6'h1f)
    else $error("multiblock length wrong");
  ext_multiblock_timing_clock_next_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r != 2'h0 |-> ##32 EXT_MULTIBLOCK_TIMING_CLOCK_EDGE)
    else $error("timing clock period wrong");
  end_mark_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r >= 2'h2 |-> str_r[31:27] == 5'h10)
    else $error("end pattern missing");
  emb_flag_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r >= 2'h2 |-> str_r[22])
    else $error("extended end flag clear");
  pilot_ones_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r >= 2'h2 |-> (str_r & 32'h80a8_8888) == 32'h80a8_8888)
    else $error("fixed ones missing");
  cmd_zero_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r >= 2'h2 |-> (str_r & 32'h0717_0000) == 32'h0000_0000)
    else $error("command bits set");
  crc_carry_a: assert property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r == 2'h3 |-> field(str_r) == crc_prev_r)
    else $error("carried crc wrong");

  cover property (EXT_MULTIBLOCK_TIMING_CLOCK_EDGE && ecnt_r == 2'h3);
  cover property (blk_valid && blk[1:0] == 2'h2);
  cover property (blk_valid && blk[1:0] == 2'h1);
endmodule // lbfc_props
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, reset_n, sysref, sysref2, fec_fmt, pay_valid;
  logic [63:0] pay_data, rx_data, d, prev_d;
  logic ext_multiblock_timing_clock_edge, aligned, rx_valid, mb_lock, mb_end, emb_end, hdr_err, crc_err;
  logic lock2, hdr_err2, crc_err2, need2, perr, need1;
  logic [31:0] sw;
  logic [15:0] mbc;
  int bad_count, total_checks, cycles, n_err, n_end, n_emb, n_hdr2, n_crc2, n_ext_multiblock_timing_clock, n_perr;
  logic [63:0] txq[$];
  lbfc_link_if link ();
  lbfc_link_if link2 ();

  lbfc_tx_framer i_lbfc_tx_framer (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SYSREF(sysref),
    .PAY_DATA(pay_data), .PAY_VALID(pay_valid), .EXT_MULTIBLOCK_TIMING_CLOCK_EDGE(ext_multiblock_timing_clock_edge), .SYSREF_PHASE_ERR(perr),
    .EXT_MULTIBLOCK_TIMING_CLOCK_ALIGNED(aligned), .STREAM_WORD(sw), .MB_COUNT(mbc), .link(link.tx));
  lbfc_rx_checker i_lbfc_rx_checker (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SYSREF(sysref),
    .FEC_FMT(fec_fmt), .PAY_DATA(rx_data), .PAY_VALID(rx_valid), .MB_LOCK(mb_lock), .MB_END(mb_end),
    .EMB_END(emb_end), .HDR_ERR(hdr_err), .CRC_ERR(crc_err), .NEED_SYSREF(need1), .link(link.rx));
  // second receiver faces a bench driver that breaks the stream on purpose
  lbfc_rx_checker i_lbfc_rx_checker_b (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SYSREF(sysref2),
    .FEC_FMT(1'b0), .PAY_DATA(), .PAY_VALID(), .MB_LOCK(lock2), .MB_END(), .EMB_END(),
    .HDR_ERR(hdr_err2), .CRC_ERR(crc_err2), .NEED_SYSREF(need2), .link(link2.rx));
  lbfc_props u_props (.CLK_SYS(clk_sys), .RESET_N(reset_n), .blk(link.blk),
    .blk_valid(link.blk_valid), .EXT_MULTIBLOCK_TIMING_CLOCK_EDGE(ext_multiblock_timing_clock_edge));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // octets keep their slots, but each goes out msb first
  function automatic logic [63:0] place(input logic [63:0] v);
    for (int b = 0; b < 64; b++) begin
      place[(b & 56) + 7 - (b & 7)] = v[b];
    end
  endfunction

  task automatic run(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      pay_data = {$urandom, $urandom};
      pay_valid = ($urandom % 4) != 0;
      txq.push_back(pay_valid ? pay_data : 64'h0);
    end
  endtask

  task automatic do_reset(input logic fec);
    @(negedge clk_sys);
    reset_n = 1'b0;
    fec_fmt = fec;
    txq.delete();
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    @(posedge clk_sys);
  endtask

  // zero payload keeps the true crc at zero, so only the stream word matters
  task automatic mb2(input logic [31:0] w, input int nbad);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk_sys);
      link2.blk = {64'h0, (i < nbad) ? 2'h0 : (w[i] ? lbfc_pkg::HDR_ONE : lbfc_pkg::HDR_ZERO)};
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  always @(posedge clk_sys) begin
    #1;
    if (link.blk_valid === 1'b1 && txq.size() > 0) begin
      d = txq.pop_front();
      check(link.blk[65:2], place(d));
      if (rx_valid === 1'b1) check(rx_data, prev_d);
      prev_d = d;
    end
    if (hdr_err === 1'b1 || crc_err === 1'b1) n_err++;
    if (mb_end === 1'b1) n_end++;
    if (emb_end === 1'b1) n_emb++;
    if (hdr_err2 === 1'b1) n_hdr2++;
    if (crc_err2 === 1'b1) n_crc2++;
    if (perr === 1'b1) n_perr++;
    if (reset_n !== 1'b1) n_ext_multiblock_timing_clock = 0;
    if (ext_multiblock_timing_clock_edge === 1'b1) begin
      n_ext_multiblock_timing_clock++;
      check(64'(mbc), 64'(n_ext_multiblock_timing_clock));
      check(64'(sw & 32'hf8e8_8888), 64'h80e8_8888);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(96931));
    reset_n = 1'b0;
    sysref = 1'b0;
    sysref2 = 1'b0;
    fec_fmt = 1'b0;
    pay_valid = 1'b0;
    pay_data = 64'h0;
    link2.blk = 66'h0;
    link2.blk_valid = 1'b1;
    do_reset(1'b0);
    run(5);
    // one sysref pulse, no continuous train
    sysref = 1'b1;
    run(15);
    sysref = 1'b0;
    run(200);
    check(64'(aligned), 64'h1);
    check(64'(mb_lock), 64'h1);
    check(64'(n_emb == n_end && n_end > 0), 64'h1);
    check(64'(n_err), 64'h0);
    check(64'(n_perr), 64'h0);
    check(64'(need1), 64'h0);
    do_reset(1'b1);
    run(250);
    check(64'(mb_lock), 64'h1);
    repeat (3) mb2(32'h80e8_8888, 0);
    check(64'(lock2), 64'h1);
    mb2(32'h80e8_8889, 0);
    mb2(32'h80e8_8888, 0);
    check(64'(n_crc2), 64'h1);
    mb2(32'h80e8_8888, 4);
    mb2(32'h80e8_8888, 0);
    check(64'(n_hdr2), 64'h4);
    check(64'({lock2, need2}), 64'h1);
    @(negedge clk_sys);
    sysref2 = 1'b1;
    repeat (4) @(negedge clk_sys);
    sysref2 = 1'b0;
    repeat (2) mb2(32'h80e8_8888, 0);
    check(64'({lock2, need2}), 64'h2);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
